/* File: tx_sched_map.vh */
`ifndef TX_SCHED_MAP_VH
`define TX_SCHED_MAP_VH

// Source codes carried in each queued transmit word
`define SRC_L2 3'h0
`define SRC_GXU 3'h1
`define SRC_USER_BASE 3'h2

// Round robin positions: 0..3 information queues, 4..5 unnumbered queues
`define RR_FIRST 3'h0
`define RR_LAST_IQ 3'h3
`define RR_LAST 3'h5
`define USER_QUEUES 6
`define INFO_QUEUES 4

// Link context store
`define LINKS 16
`define LINK_W 4
`define DESC_W 8
`define SEQ_W 3
`define QUOTA_W 8
`define QUOTA_RESET 8'h00

// Transmit word FIFO
`define WORD_W 15
`define FIFO_DEPTH 32
`define FIFO_AW 5

`endif

/* File: tx_queue_scheduler.v */
`timescale 1ns/1ps
`include "tx_sched_map.vh"

module tx_word_fifo #(
    parameter W = 15,
    parameter D = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire reset,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    // Depth must be a power of two so the top count bit means full
    assign in_ready = ~count_q[AW];
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_q];

    // Pointers and occupancy
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // Storage needs no reset; only counted words are ever read
    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule // tx_word_fifo

module tx_queue_scheduler (
    input wire clk,
    input wire reset,
    input wire l2_avail,
    output reg l2_take,
    input wire gxu_avail,
    output reg gxu_take,
    input wire [1:0] xu_avail,
    output reg [1:0] xu_take,
    input wire [`QUOTA_W-1:0] quota_iq0,
    input wire [`QUOTA_W-1:0] quota_iq1,
    input wire [`QUOTA_W-1:0] quota_iq2,
    input wire [`QUOTA_W-1:0] quota_iq3,
    input wire [`QUOTA_W-1:0] quota_xu0,
    input wire [`QUOTA_W-1:0] quota_xu1,
    input wire reload_cmd,
    input wire queue_data_request_cmd,
    input wire [`LINK_W-1:0] link_identifier,
    input wire [1:0] req_queue,
    input wire [`DESC_W-1:0] req_first_desc,
    input wire [`DESC_W-1:0] req_frame_count,
    input wire [`SEQ_W-1:0] req_window,
    input wire ack_valid,
    input wire [`LINK_W-1:0] ack_link,
    input wire [`LINKS-1:0] link_inhibit,
    output wire tx_valid,
    input wire tx_ready,
    output wire [`WORD_W-1:0] tx_word,
    output wire [2:0] rr_index,
    output wire [`INFO_QUEUES-1:0] iq_nonempty
);
    // Per-link context entries
    reg [`DESC_W-1:0] send_ptr_q [0:`LINKS-1];
    reg [`DESC_W-1:0] ack_ptr_q [0:`LINKS-1];
    reg [`LINK_W-1:0] next_link_ptr [0:`LINKS-1];
    reg [`DESC_W-1:0] remain_q [0:`LINKS-1];
    reg [`SEQ_W-1:0] vs_q [0:`LINKS-1];
    reg [`SEQ_W-1:0] va_q [0:`LINKS-1];
    reg [`SEQ_W-1:0] window_q [0:`LINKS-1];
    reg [1:0] assign_q [0:`LINKS-1];
    reg [`LINKS-1:0] queue_tail_marker;
    reg [`LINKS-1:0] linked_q;
    // Queue pointers and round robin state
    reg [`LINK_W-1:0] head_q [0:`INFO_QUEUES-1];
    reg [`LINK_W-1:0] tail_q [0:`INFO_QUEUES-1];
    reg [`INFO_QUEUES-1:0] qvalid_q;
    reg [`QUOTA_W-1:0] quota_q [0:`USER_QUEUES-1];
    reg [`QUOTA_W-1:0] used_q;
    reg [2:0] rr_q;
    reg [`LINK_W-1:0] scan_q;
    // Decisions of the current cycle
    reg push;
    reg [`WORD_W-1:0] word;
    reg pop;
    reg send;
    reg rr_adv;
    reg credit_dec;
    wire fifo_ready;
    wire [1:0] iq;
    wire [`LINK_W-1:0] h;
    wire [`QUOTA_W-1:0] cur_quota;
    wire cmd_ok;
    wire reloc_ok;
    wire app;
    wire [`LINK_W-1:0] a;
    wire [1:0] qa;
    integer i, j, k;

    // Link may not send: inhibited, window full or list empty
    function blocked;
        input [`LINK_W-1:0] l;
        reg [`SEQ_W-1:0] d;
        begin
            d = vs_q[l] - va_q[l];
            blocked = link_inhibit[l] | (d >= window_q[l]) | (remain_q[l] == {`DESC_W{1'b0}});
        end
    endfunction
    assign iq = rr_q[1:0];
    assign h = head_q[iq];
    assign cur_quota = quota_q[rr_q];
    assign rr_index = rr_q;
    assign iq_nonempty = qvalid_q;
    // A new request beats the background relink scan, which simply retries next lap
    assign cmd_ok = queue_data_request_cmd & ~linked_q[link_identifier];
    assign reloc_ok = ~cmd_ok & ~linked_q[scan_q] & ~blocked(scan_q);
    assign app = cmd_ok | reloc_ok;
    assign a = cmd_ok ? link_identifier : scan_q;
    assign qa = cmd_ok ? req_queue : assign_q[scan_q];
    // One frame decision per cycle; each push is a frame boundary
    always @* begin
        push = 1'b0;
        word = {`WORD_W{1'b0}};
        pop = 1'b0;
        send = 1'b0;
        rr_adv = 1'b0;
        credit_dec = 1'b0;
        l2_take = 1'b0;
        gxu_take = 1'b0;
        xu_take = 2'b00;
        if (fifo_ready) begin
            if (l2_avail) begin
                push = 1'b1;
                l2_take = 1'b1;
                word = {`SRC_L2, {(`WORD_W-3){1'b0}}};
            end else if (gxu_avail) begin
                push = 1'b1;
                gxu_take = 1'b1;
                word = {`SRC_GXU, {(`WORD_W-3){1'b0}}};
            end else if (cur_quota == `QUOTA_RESET || used_q >= cur_quota) begin
                rr_adv = 1'b1;
            end else if (rr_q <= `RR_LAST_IQ) begin
                if (!qvalid_q[iq]) begin
                    rr_adv = 1'b1;
                end else if (blocked(h)) begin
                    pop = 1'b1;
                end else begin
                    push = 1'b1;
                    send = 1'b1;
                    credit_dec = 1'b1;
                    word = {`SRC_USER_BASE + rr_q, h, send_ptr_q[h]};
                    // Last frame of the list: unlink and go on to the next entry
                    if (remain_q[h] == {{(`DESC_W-1){1'b0}}, 1'b1}) begin
                        pop = 1'b1;
                    end
                end
            end else if (xu_avail[rr_q[0]]) begin
                push = 1'b1;
                credit_dec = 1'b1;
                xu_take[rr_q[0]] = 1'b1;
                word = {`SRC_USER_BASE + rr_q, {(`WORD_W-3){1'b0}}};
            end else begin
                rr_adv = 1'b1;
            end
        end
    end

    // Round robin position and frame count; untouched while preempted
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rr_q <= `RR_FIRST;
            used_q <= {`QUOTA_W{1'b0}};
            scan_q <= {`LINK_W{1'b0}};
            for (i = 0; i < `USER_QUEUES; i = i + 1) begin
                quota_q[i] <= `QUOTA_RESET;
            end
        end else begin
            scan_q <= scan_q + 1'b1;
            if (reload_cmd) begin
                quota_q[0] <= quota_iq0;
                quota_q[1] <= quota_iq1;
                quota_q[2] <= quota_iq2;
                quota_q[3] <= quota_iq3;
                quota_q[4] <= quota_xu0;
                quota_q[5] <= quota_xu1;
            end
            if (rr_adv || (credit_dec && used_q + 1'b1 >= cur_quota)) begin
                used_q <= {`QUOTA_W{1'b0}};
                rr_q <= (rr_q == `RR_LAST) ? `RR_FIRST : rr_q + 1'b1;
            end else if (credit_dec) begin
                used_q <= used_q + 1'b1;
            end
        end
    end

    // Queue head, tail and valid per information queue
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            qvalid_q <= {`INFO_QUEUES{1'b0}};
            for (j = 0; j < `INFO_QUEUES; j = j + 1) begin
                head_q[j] <= {`LINK_W{1'b0}};
                tail_q[j] <= {`LINK_W{1'b0}};
            end
        end else begin
            for (j = 0; j < `INFO_QUEUES; j = j + 1) begin
                if (pop && iq == j) begin
                    if (!queue_tail_marker[h]) begin
                        head_q[j] <= next_link_ptr[h];
                    end else if (app && qa == j) begin
                        head_q[j] <= a;
                    end else begin
                        qvalid_q[j] <= 1'b0;
                    end
                end else if (app && qa == j && !qvalid_q[j]) begin
                    head_q[j] <= a;
                    qvalid_q[j] <= 1'b1;
                end
                if (app && qa == j) begin
                    tail_q[j] <= a;
                end
            end
        end
    end

    // Link context entries; only this logic rewrites the links
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            queue_tail_marker <= {`LINKS{1'b0}};
            linked_q <= {`LINKS{1'b0}};
            for (k = 0; k < `LINKS; k = k + 1) begin
                send_ptr_q[k] <= {`DESC_W{1'b0}};
                ack_ptr_q[k] <= {`DESC_W{1'b0}};
                next_link_ptr[k] <= {`LINK_W{1'b0}};
                remain_q[k] <= {`DESC_W{1'b0}};
                vs_q[k] <= {`SEQ_W{1'b0}};
                va_q[k] <= {`SEQ_W{1'b0}};
                window_q[k] <= {`SEQ_W{1'b0}};
                assign_q[k] <= 2'b00;
            end
        end else begin
            if (pop) begin
                linked_q[h] <= 1'b0;
            end
            if (app) begin
                linked_q[a] <= 1'b1;
                queue_tail_marker[a] <= 1'b1;
                // Old tail may be the entry popped now; rewriting it is harmless
                if (qvalid_q[qa]) begin
                    next_link_ptr[tail_q[qa]] <= a;
                    queue_tail_marker[tail_q[qa]] <= 1'b0;
                end
            end
            if (send) begin
                send_ptr_q[h] <= send_ptr_q[h] + 1'b1;
                vs_q[h] <= vs_q[h] + 1'b1;
                remain_q[h] <= remain_q[h] - 1'b1;
            end
            if (ack_valid) begin
                ack_ptr_q[ack_link] <= ack_ptr_q[ack_link] + 1'b1;
                va_q[ack_link] <= va_q[ack_link] + 1'b1;
            end
            // A fresh request overrides the ack pointer of a same-cycle acknowledge on that link; the va_q step still lands
            if (cmd_ok) begin
                send_ptr_q[a] <= req_first_desc;
                ack_ptr_q[a] <= req_first_desc;
                remain_q[a] <= req_frame_count;
                window_q[a] <= req_window;
                assign_q[a] <= req_queue;
            end
        end
    end

    // Words wait here so a slow line stalls the scheduler, not the queues
    tx_word_fifo #(
        .W(`WORD_W),
        .D(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(word),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_word)
    );
endmodule // tx_queue_scheduler

/* File: tx_sched_checker_properties.sv */
`timescale 1ns/1ps
module tx_sched_checker (
    input wire clk,
    input wire reset,
    input wire l2_avail,
    input wire l2_take,
    input wire gxu_avail,
    input wire gxu_take,
    input wire [1:0] xu_take,
    input wire [2:0] rr_index
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // A frame went to one of the two higher queues
    sequence s_high;
        l2_take || gxu_take;
    endsequence
    // Priority of every take and position of unnumbered queue takes
    a_take_has_frame: assert property ((!l2_take || l2_avail) && (!gxu_take || gxu_avail))
        else $error("take without a waiting frame");
    a_gxu_after_l2: assert property (gxu_take |-> !l2_avail)
        else $error("global taken while protocol waits");
    a_user_after_high: assert property (xu_take != 2'h0 |-> !l2_avail && !gxu_avail)
        else $error("user taken while higher waits");
    a_xu_position: assert property (xu_take != 2'h0 |-> rr_index == (xu_take[1] ? 3'h5 : 3'h4))
        else $error("unnumbered take at wrong position");
    a_rr_range: assert property (rr_index <= 3'h5)
        else $error("position out of range");
    a_one_take: assert property ($onehot0({l2_take, gxu_take, xu_take}))
        else $error("more than one take in a cycle");
    // Preemption must not move the round robin
    a_preempt_hold: assert property (s_high |=> $stable(rr_index))
        else $error("position moved during preemption");
    a_rr_step: assert property (!$stable(rr_index) |->
        rr_index == ($past(rr_index) == 3'h5 ? 3'h0 : $past(rr_index) + 3'h1))
        else $error("position skipped a queue");
endmodule // tx_sched_checker

/* File: tx_far_side.sv */
`timescale 1ns/1ps
module tx_far_side (
    input wire clk,
    input wire l2_take,
    input wire gxu_take,
    input wire [1:0] xu_take,
    input wire stall,
    output wire l2_avail,
    output wire gxu_avail,
    output wire [1:0] xu_avail,
    output wire tx_ready
);
    // Frame counts only; queue links stay with the scheduler
    int l2_n = 0;
    int gxu_n = 0;
    int xu0_n = 0;
    int xu1_n = 0;
    // A queue offers a frame while its count is nonzero
    assign l2_avail = l2_n != 0;
    assign gxu_avail = gxu_n != 0;
    assign xu_avail = {xu1_n != 0, xu0_n != 0};
    // Full stall, so the FIFO can be seen to fill
    assign tx_ready = !stall;
    // One frame leaves its queue per take
    always @(posedge clk) begin
        if (l2_take) l2_n <= l2_n - 1;
        if (gxu_take) gxu_n <= gxu_n - 1;
        if (xu_take[0]) xu0_n <= xu0_n - 1;
        if (xu_take[1]) xu1_n <= xu1_n - 1;
    end
endmodule // tx_far_side

/* File: tx_queue_scheduler_tb_top.sv */
`timescale 1ns/1ps
module tx_queue_scheduler_tb_top;
    logic clk, reset, stall, reload_cmd, req_cmd, ack_valid;
    logic l2_avail, l2_take, gxu_avail, gxu_take, tx_valid, tx_ready;
    logic [1:0] xu_avail, xu_take, rq;
    logic [2:0] win, rr_index;
    logic [3:0] lid, ack_link, iq_nonempty;
    logic [7:0] fd, fc;
    logic [7:0] qt [6];
    logic [14:0] tx_word;
    logic [15:0] inh;
    logic [14:0] got [$];
    logic [14:0] exp [$];
    time xt [$];
    int failures, num_checks, i;
    tx_far_side i_far (.clk(clk), .l2_take(l2_take), .gxu_take(gxu_take), .xu_take(xu_take), .stall(stall),
        .l2_avail(l2_avail), .gxu_avail(gxu_avail), .xu_avail(xu_avail), .tx_ready(tx_ready));
    tx_queue_scheduler i_dut (.clk(clk), .reset(reset), .l2_avail(l2_avail), .l2_take(l2_take),
        .gxu_avail(gxu_avail), .gxu_take(gxu_take), .xu_avail(xu_avail), .xu_take(xu_take),
        .quota_iq0(qt[0]), .quota_iq1(qt[1]), .quota_iq2(qt[2]), .quota_iq3(qt[3]), .quota_xu0(qt[4]),
        .quota_xu1(qt[5]), .reload_cmd(reload_cmd), .queue_data_request_cmd(req_cmd), .link_identifier(lid),
        .req_queue(rq), .req_first_desc(fd), .req_frame_count(fc), .req_window(win), .ack_valid(ack_valid),
        .ack_link(ack_link), .link_inhibit(inh), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
        .rr_index(rr_index), .iq_nonempty(iq_nonempty));
    // Clock
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // Words accepted at the sink, and the times of unnumbered queue takes
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_word);
        if (xu_take != 2'b00) xt.push_back($time);
    end
    // Inputs move 1 ns after the edge so sampling never races
    task automatic tk(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic w(logic [2:0] s, logic [3:0] l, logic [7:0] d, int n);
        for (int k = 0; k < n; k++) exp.push_back({s, l, d + k[7:0]});
    endtask
    task automatic setq(logic [7:0] a, logic [7:0] b, logic [7:0] c, logic [7:0] e, logic [7:0] f);
        qt = '{a, b, c, 8'h08, e, f};
        reload_cmd = 1;
        tk(1);
        reload_cmd = 0;
        tk(1);
    endtask
    task automatic req(logic [3:0] l, logic [1:0] q, logic [7:0] d, logic [7:0] n, logic [2:0] k);
        {lid, rq, fd, fc, win} = {l, q, d, n, k};
        req_cmd = 1;
        tk(1);
        req_cmd = 0;
        tk(1);
    endtask
    task automatic ack(logic [3:0] l);
        ack_link = l;
        ack_valid = 1;
        tk(1);
        ack_valid = 0;
        tk(1);
    endtask
    // Wait for n words, then 20 quiet cycles, so extra words are caught too
    task automatic drain(int n);
        for (i = 0; i < 200 && got.size() < n; i++) tk(1);
        tk(20);
        if (got.size() < n) begin
            failures++;
            wrap_up();
        end
        chk("word count", n, got.size());
        foreach (exp[k]) chk("word", exp[k], got[k]);
        got.delete();
        exp.delete();
        xt.delete();
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {reset, stall, reload_cmd, req_cmd, ack_valid} = 5'h10;
        {lid, rq, fd, fc, win, ack_link, inh} = '0;
        qt = '{default: 8'h00};
        tk(2);
        chk("reset state", 8'h00, {rr_index, iq_nonempty, tx_valid});
        reset = 0;
        $display("reset test done");
        stall = 1;
        i_far.l2_n = 40;
        tk(45);
        chk("protocol left", 8, i_far.l2_n);
        stall = 0;
        repeat (40) w(3'h0, 4'h0, 8'h00, 1);
        drain(40);
        $display("fill test done");
        setq(8'h00, 8'h00, 8'h00, 8'h02, 8'h00);
        {i_far.l2_n, i_far.gxu_n, i_far.xu0_n, i_far.xu1_n} = {32'd2, 32'd2, 32'd3, 32'd3};
        w(3'h0, 4'h0, 8'h00, 1);
        w(3'h0, 4'h0, 8'h00, 1);
        w(3'h1, 4'h0, 8'h00, 1);
        w(3'h1, 4'h0, 8'h00, 1);
        repeat (3) w(3'h6, 4'h0, 8'h00, 1);
        // Let the seven expected frames pass before the take times are read
        tk(30);
        chk("visit gap", 4, xt[1] - xt[0]);
        chk("cycle gap", 24, xt[2] - xt[1]);
        drain(7);
        chk("zero quota queue", 3, i_far.xu1_n);
        $display("priority test done");
        setq(8'h00, 8'h00, 8'h00, 8'h03, 8'h00);
        i_far.xu0_n = 4;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (xu_take[0]) break;
        end
        if (i == 50) begin
            failures++;
            wrap_up();
        end
        #1 i_far.l2_n = 1;
        w(3'h6, 4'h0, 8'h00, 1);
        w(3'h0, 4'h0, 8'h00, 1);
        repeat (3) w(3'h6, 4'h0, 8'h00, 1);
        tk(40);
        chk("preempt gap", 8, xt[1] - xt[0]);
        chk("resume gap", 24, xt[3] - xt[2]);
        drain(5);
        $display("preempt test done");
        setq(8'h08, 8'h08, 8'h01, 8'h00, 8'h00);
        req(4'h3, 2'h1, 8'h10, 8'h03, 3'h7);
        w(3'h3, 4'h3, 8'h10, 3);
        drain(3);
        req(4'h5, 2'h2, 8'h20, 8'h03, 3'h7);
        req(4'h9, 2'h2, 8'h40, 8'h01, 3'h7);
        w(3'h4, 4'h5, 8'h20, 3);
        w(3'h4, 4'h9, 8'h40, 1);
        drain(4);
        chk("queues empty", 0, iq_nonempty);
        $display("info queue test done");
        req(4'h7, 2'h0, 8'h30, 8'h04, 3'h2);
        w(3'h2, 4'h7, 8'h30, 2);
        drain(2);
        chk("blocked removed", 0, iq_nonempty);
        ack(4'h7);
        w(3'h2, 4'h7, 8'h32, 1);
        drain(1);
        inh = 16'h0080;
        ack(4'h7);
        drain(0);
        inh = 16'h0000;
        w(3'h2, 4'h7, 8'h33, 1);
        drain(1);
        $display("window test done");
        // Second unnumbered queue: the three frames left waiting since the zero quota test
        setq(8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
        repeat (3) w(3'h7, 4'h0, 8'h00, 1);
        tk(30);
        chk("unnumbered 1 gap", 24, xt[1] - xt[0]);
        drain(3);
        chk("unnumbered 1 left", 0, i_far.xu1_n);
        $display("unnumbered 1 test done");
        wrap_up();
    end
endmodule // tx_queue_scheduler_tb_top

bind tx_queue_scheduler tx_sched_checker i_chk (.clk(clk), .reset(reset), .l2_avail(l2_avail),
    .l2_take(l2_take), .gxu_avail(gxu_avail), .gxu_take(gxu_take), .xu_take(xu_take), .rr_index(rr_index));
